// file: shared/sfp_pkg.sv
// Shared constants, types and decoders for the serial flash program/erase host
package sfp_pkg;

	// ----------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 20_000_000;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SCK_HALF_CYCLES = 4;
	localparam int SCK_CNT_W       = 3;
	localparam logic [SCK_CNT_W-1:0] SCK_HALF_M1 = SCK_CNT_W'(SCK_HALF_CYCLES - 1);
	localparam logic [SCK_CNT_W-1:0] SCK_LAST    = SCK_CNT_W'(2 * SCK_HALF_CYCLES - 1);

	// ----------------------------------------------------------------
	// Frame timing
	// ----------------------------------------------------------------
	localparam int CS_HIGH_TIME_NS = 50;
	localparam int CS_HIGH_CYCLES  = (CS_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CNT_W       = 4;
	localparam int PAGE_PROGRAM_TIME_MS = 5;
	localparam int SECTOR_ERASE_TIME_S  = 3;
	localparam int BULK_ERASE_TIME_S    = 480;
	localparam int DIE_ERASE_TIME_S     = 480;
	localparam int TIMER_W              = 40;
	localparam logic [TIMER_W-1:0] PAGE_PROGRAM_CYCLES =
		TIMER_W'(PAGE_PROGRAM_TIME_MS) * TIMER_W'(CLK_HZ / 1000);
	localparam logic [TIMER_W-1:0] SECTOR_ERASE_CYCLES =
		TIMER_W'(SECTOR_ERASE_TIME_S) * TIMER_W'(CLK_HZ);
	localparam logic [TIMER_W-1:0] BULK_ERASE_CYCLES =
		TIMER_W'(BULK_ERASE_TIME_S) * TIMER_W'(CLK_HZ);
	localparam logic [TIMER_W-1:0] DIE_ERASE_CYCLES =
		TIMER_W'(DIE_ERASE_TIME_S) * TIMER_W'(CLK_HZ);

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int CMD_BITS   = 8;
	localparam int ADDR_BITS  = 32;
	localparam int BYTE_BITS  = 8;
	localparam int QUAD_STEP  = 4;
	localparam int LEN_W      = 8;
	localparam int BUF_DEPTH  = 2;

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] OPC_ID_READ         = 8'h9F;
	localparam logic [7:0] OPC_PAGE_WRITE      = 8'h02;
	localparam logic [7:0] OPC_QUAD_PAGE_WRITE = 8'h12;
	localparam logic [7:0] OPC_BULK_ERASE      = 8'hC7;
	localparam logic [7:0] OPC_DIE_ERASE       = 8'hC4;
	localparam logic [7:0] OPC_SECTOR_ERASE    = 8'hD8;

	typedef enum logic [2:0] {
		OP_ID_READ,
		OP_PAGE_WRITE,
		OP_QUAD_PAGE_WRITE,
		OP_BULK_ERASE,
		OP_DIE_ERASE,
		OP_SECTOR_ERASE
	} sfp_op_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_CMD, ST_ADDR, ST_DATA, ST_ID, ST_HOLD, ST_GAP, ST_WAIT
	} sfp_state_t;

	function automatic logic [7:0] sfp_opcode(input sfp_op_t op);
		case (op)
			OP_ID_READ:         return OPC_ID_READ;
			OP_PAGE_WRITE:      return OPC_PAGE_WRITE;
			OP_QUAD_PAGE_WRITE: return OPC_QUAD_PAGE_WRITE;
			OP_BULK_ERASE:      return OPC_BULK_ERASE;
			OP_DIE_ERASE:       return OPC_DIE_ERASE;
			OP_SECTOR_ERASE:    return OPC_SECTOR_ERASE;
			default:            return OPC_ID_READ;
		endcase
	endfunction : sfp_opcode

	function automatic logic sfp_is_legal(input sfp_op_t op);
		return op <= OP_SECTOR_ERASE;
	endfunction : sfp_is_legal

	function automatic logic sfp_is_write(input sfp_op_t op);
		return (op == OP_PAGE_WRITE) || (op == OP_QUAD_PAGE_WRITE);
	endfunction : sfp_is_write

	function automatic logic sfp_has_addr(input sfp_op_t op);
		return sfp_is_write(op) || (op == OP_DIE_ERASE) || (op == OP_SECTOR_ERASE);
	endfunction : sfp_has_addr

	function automatic logic sfp_modifies(input sfp_op_t op);
		return sfp_is_legal(op) && (op != OP_ID_READ);
	endfunction : sfp_modifies

endpackage : sfp_pkg

// file: core/sfp_buf.sv
// Small valid/ready buffer that sits in the write data path
module sfp_buf
	import sfp_pkg::*;
#(
	parameter int WIDTH = BYTE_BITS,
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	// Filling side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Draining side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	assign in_ready_out  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW])
		&& (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid_out = (wr_ptr_reg != rd_ptr_reg);
	assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push          = ce_in && in_valid_in && in_ready_out;
	assign pop           = ce_in && out_valid_out && out_ready_in;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

	// Storage needs no reset: a slot is only read after it was written
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

endmodule : sfp_buf

// file: core/sfp_sclk_div.sv
// Shift clock divider with a load tick at the start of each low phase
module sfp_sclk_div
	import sfp_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic ce_in,
	// Control
	input  wire logic run_in,
	// Outputs
	output logic      sclk_out,
	output logic      at_zero_out,
	output logic      tick_out
);

	logic [SCK_CNT_W-1:0] cnt_reg;
	logic                 sclk_reg;

	assign sclk_out    = sclk_reg;
	assign at_zero_out = (cnt_reg == '0);
	assign tick_out    = ce_in && run_in && (cnt_reg == '0);

	// Stopping the clock parks it low at count zero, so a stall never cuts a pulse
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg  <= '0;
			sclk_reg <= 1'b0;
		end else if (ce_in) begin
			if (!run_in) begin
				cnt_reg  <= '0;
				sclk_reg <= 1'b0;
			end else begin
				cnt_reg <= (cnt_reg == SCK_LAST) ? '0 : cnt_reg + 1'b1;
				if (cnt_reg == SCK_HALF_M1) begin
					sclk_reg <= 1'b1;
				end else if (cnt_reg == SCK_LAST) begin
					sclk_reg <= 1'b0;
				end
			end
		end
	end

endmodule : sfp_sclk_div

// file: core/sfp_host.sv
// Host controller that drives a serial flash through program, erase and id frames
module sfp_host
	import sfp_pkg::*;
#(
	parameter logic                MULTI_DIE          = 1'b1,
	parameter logic [TIMER_W-1:0]  PAGE_PROG_CYCLES   = PAGE_PROGRAM_CYCLES,
	parameter logic [TIMER_W-1:0]  SECTOR_ER_CYCLES   = SECTOR_ERASE_CYCLES,
	parameter logic [TIMER_W-1:0]  BULK_ER_CYCLES     = BULK_ERASE_CYCLES,
	parameter logic [TIMER_W-1:0]  DIE_ER_CYCLES      = DIE_ERASE_CYCLES
) (
	// Clock, reset and enable
	input  wire logic                  ref_clk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  ce_in,
	// Command request
	input  wire logic                  cmd_valid_in,
	output logic                       cmd_ready_out,
	input  wire logic [2:0]            cmd_op_in,
	input  wire logic [ADDR_BITS-1:0]  cmd_addr_in,
	input  wire logic [LEN_W-1:0]      cmd_len_m1_in,
	// Page data stream
	input  wire logic                  wr_valid_in,
	output logic                       wr_ready_out,
	input  wire logic [BYTE_BITS-1:0]  wr_data_in,
	// Results and status
	output logic [BYTE_BITS-1:0]       id_data_out,
	output logic                       id_valid_out,
	output logic                       done_out,
	output logic                       busy_out,
	// Flash pins
	output logic                       select_low_out,
	output logic                       shift_clock_out,
	output logic                       serial_in_line_out,
	output logic                       serial_in_line_oe_out,
	input  wire logic                  serial_out_line_in,
	output logic                       serial_out_line_out,
	output logic                       serial_out_line_oe_out,
	output logic                       quad_line_2_out,
	output logic                       quad_line_2_oe_out,
	output logic                       quad_line_3_out,
	output logic                       quad_line_3_oe_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sfp_state_t             state_reg;
	sfp_state_t             state_next;
	sfp_op_t                op_reg;
	sfp_op_t                req_op;
	logic                   wen_phase_reg;
	logic [ADDR_BITS-1:0]   addr_reg;
	logic [LEN_W:0]         bytes_left_reg;
	logic [GAP_CNT_W-1:0]   gap_cnt_reg;
	logic [TIMER_W-1:0]     timer_reg;
	logic                   select_low_reg;
	logic                   done_reg;
	logic [ADDR_BITS-1:0]   sh_reg;
	logic [ADDR_BITS-1:0]   sh_next;
	logic [5:0]             left_reg;
	logic [5:0]             left_next;
	logic                   quad_reg;
	logic                   quad_next;
	logic [3:0]             lines_reg;
	logic [BYTE_BITS-1:0]   id_sh_reg;
	logic [BYTE_BITS-1:0]   id_data_reg;
	logic                   id_valid_reg;
	logic                   sout_meta_reg;
	logic                   sout_sync_reg;
	logic                   pop;
	logic                   shifting;
	logic                   stall;
	logic                   run;
	logic                   at_zero;
	logic                   tick;
	logic                   buf_valid;
	logic [BYTE_BITS-1:0]   buf_data;
	logic                   frame_addr;
	logic                   frame_data;
	logic                   frame_id;
	logic [7:0]             frame_opcode;

	// Timed wait stands in for status polling; the worst case is always covered
	function automatic logic [TIMER_W-1:0] wait_cycles(input sfp_op_t op);
		case (op)
			OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE: return PAGE_PROG_CYCLES;
			OP_SECTOR_ERASE:                   return SECTOR_ER_CYCLES;
			OP_DIE_ERASE:                      return DIE_ER_CYCLES;
			default:                           return BULK_ER_CYCLES;
		endcase
	endfunction : wait_cycles

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	sfp_buf #(
		.WIDTH (BYTE_BITS),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_in        (ref_clk_in),
		.rstn_in       (rstn_in),
		.ce_in         (ce_in),
		.in_valid_in   (wr_valid_in),
		.in_ready_out  (wr_ready_out),
		.in_data_in    (wr_data_in),
		.out_valid_out (buf_valid),
		.out_ready_in  (tick && pop),
		.out_data_out  (buf_data)
	);

	sfp_sclk_div u_div (
		.clk_in      (ref_clk_in),
		.rstn_in     (rstn_in),
		.ce_in       (ce_in),
		.run_in      (run),
		.sclk_out    (shift_clock_out),
		.at_zero_out (at_zero),
		.tick_out    (tick)
	);

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	// Die erase falls back to bulk erase on a single-die part
	assign req_op = (sfp_op_t'(cmd_op_in) == OP_DIE_ERASE && !MULTI_DIE)
		? OP_BULK_ERASE : sfp_op_t'(cmd_op_in);

	assign frame_opcode = wen_phase_reg ? OPC_WRITE_ENABLE : sfp_opcode(op_reg);
	assign frame_addr   = !wen_phase_reg && sfp_has_addr(op_reg);
	assign frame_data   = !wen_phase_reg && sfp_is_write(op_reg);
	assign frame_id     = !wen_phase_reg && (op_reg == OP_ID_READ);

	assign shifting = (state_reg == ST_SETUP) || (state_reg == ST_CMD)
		|| (state_reg == ST_ADDR) || (state_reg == ST_DATA) || (state_reg == ST_ID);
	// Select stays low while the clock is parked for data, so the frame never splits
	assign stall = at_zero && (left_reg == '0) && frame_data && (bytes_left_reg != '0)
		&& ((state_reg == ST_ADDR) || (state_reg == ST_DATA)) && !buf_valid;
	assign run = shifting && !stall;

	// ----------------------------------------------------------------
	// Segment sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		sh_next    = sh_reg;
		left_next  = left_reg;
		quad_next  = quad_reg;
		pop        = 1'b0;
		if (left_reg == '0) begin
			unique case (state_reg)
				ST_SETUP: begin
					state_next = ST_CMD;
					sh_next    = {frame_opcode, 24'h000000};
					left_next  = 6'(CMD_BITS);
					quad_next  = 1'b0;
				end
				ST_CMD: begin
					if (frame_id) begin
						state_next = ST_ID;
						left_next  = 6'(BYTE_BITS);
					end else if (frame_addr) begin
						state_next = ST_ADDR;
						sh_next    = addr_reg;
						left_next  = 6'(ADDR_BITS);
						quad_next  = (op_reg == OP_QUAD_PAGE_WRITE);
					end else begin
						state_next = ST_HOLD;
					end
				end
				ST_ADDR, ST_DATA: begin
					if (frame_data && bytes_left_reg != '0) begin
						state_next = ST_DATA;
						sh_next    = {buf_data, 24'h000000};
						left_next  = 6'(BYTE_BITS);
						pop        = 1'b1;
					end else begin
						state_next = ST_HOLD;
					end
				end
				ST_ID: begin
					state_next = ST_HOLD;
				end
				ST_IDLE, ST_HOLD, ST_GAP, ST_WAIT: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shift register and line drive
	// ----------------------------------------------------------------
	// Bits change at the start of the low phase; the flash samples on the rise
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sh_reg    <= '0;
			left_reg  <= '0;
			quad_reg  <= 1'b0;
			lines_reg <= 4'h0;
		end else if (tick) begin
			if (state_next == ST_HOLD) begin
				quad_reg  <= 1'b0;
				lines_reg <= 4'h0;
			end else if (quad_next) begin
				sh_reg    <= sh_next << QUAD_STEP;
				left_reg  <= left_next - 6'(QUAD_STEP);
				quad_reg  <= 1'b1;
				lines_reg <= sh_next[ADDR_BITS-1 -: QUAD_STEP];
			end else begin
				sh_reg    <= sh_next << 1;
				left_reg  <= left_next - 6'h01;
				quad_reg  <= 1'b0;
				lines_reg <= {3'h0, sh_next[ADDR_BITS-1]};
			end
		end
	end

	assign serial_in_line_out     = lines_reg[0];
	assign serial_out_line_out    = lines_reg[1];
	assign quad_line_2_out        = lines_reg[2];
	assign quad_line_3_out        = lines_reg[3];
	assign serial_in_line_oe_out  = !select_low_reg;
	assign serial_out_line_oe_out = quad_reg;
	assign quad_line_2_oe_out     = quad_reg;
	assign quad_line_3_oe_out     = quad_reg;

	// ----------------------------------------------------------------
	// Identification capture
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sout_meta_reg <= 1'b0;
			sout_sync_reg <= 1'b0;
		end else if (ce_in) begin
			sout_meta_reg <= serial_out_line_in;
			sout_sync_reg <= sout_meta_reg;
		end
	end

	// Sampled just before the next fall, after the flash has settled the bit
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			id_sh_reg    <= '0;
			id_data_reg  <= '0;
			id_valid_reg <= 1'b0;
		end else if (ce_in) begin
			id_valid_reg <= 1'b0;
			if (tick && state_reg == ST_ID) begin
				id_sh_reg <= {sout_sync_reg, id_sh_reg[BYTE_BITS-1:1]};
				if (state_next == ST_HOLD) begin
					id_data_reg  <= {sout_sync_reg, id_sh_reg[BYTE_BITS-1:1]};
					id_valid_reg <= 1'b1;
				end
			end
		end
	end

	assign id_data_out  = id_data_reg;
	assign id_valid_out = id_valid_reg;

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg      <= ST_IDLE;
			op_reg         <= OP_ID_READ;
			wen_phase_reg  <= 1'b0;
			addr_reg       <= '0;
			bytes_left_reg <= '0;
			gap_cnt_reg    <= '0;
			timer_reg      <= '0;
			select_low_reg <= 1'b1;
			done_reg       <= 1'b0;
		end else if (ce_in) begin
			done_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_valid_in) begin
						op_reg         <= req_op;
						addr_reg       <= cmd_addr_in;
						bytes_left_reg <= {1'b0, cmd_len_m1_in} + 9'h001;
						wen_phase_reg  <= sfp_modifies(req_op);
						if (sfp_is_legal(req_op)) begin
							state_reg      <= ST_SETUP;
							select_low_reg <= 1'b0;
						end else begin
							done_reg <= 1'b1;
						end
					end
				end
				ST_SETUP, ST_CMD, ST_ADDR, ST_DATA, ST_ID: begin
					if (tick) begin
						state_reg <= state_next;
						if (pop) begin
							bytes_left_reg <= bytes_left_reg - 9'h001;
						end
					end
				end
				ST_HOLD: begin
					state_reg      <= ST_GAP;
					select_low_reg <= 1'b1;
					gap_cnt_reg    <= GAP_CNT_W'(CS_HIGH_CYCLES);
				end
				ST_GAP: begin
					if (gap_cnt_reg > GAP_CNT_W'(1)) begin
						gap_cnt_reg <= gap_cnt_reg - 1'b1;
					end else if (wen_phase_reg) begin
						wen_phase_reg  <= 1'b0;
						state_reg      <= ST_SETUP;
						select_low_reg <= 1'b0;
					end else if (sfp_modifies(op_reg)) begin
						state_reg <= ST_WAIT;
						timer_reg <= wait_cycles(op_reg);
					end else begin
						state_reg <= ST_IDLE;
						done_reg  <= 1'b1;
					end
				end
				ST_WAIT: begin
					// No new frame until the self-timed cycle is surely over
					if (timer_reg > TIMER_W'(1)) begin
						timer_reg <= timer_reg - 1'b1;
					end else begin
						state_reg <= ST_IDLE;
						done_reg  <= 1'b1;
					end
				end
			endcase
		end
	end

	assign select_low_out = select_low_reg;
	assign cmd_ready_out  = (state_reg == ST_IDLE);
	assign busy_out       = (state_reg != ST_IDLE);
	assign done_out       = done_reg;

endmodule : sfp_host

// file: verification/sfp_flash_model.sv
// Behavioural serial flash, one page of memory, seen from its pins
module sfp_flash_model #(
	parameter logic [7:0] ID_CODE = 8'h5A, // Arbitrary value, names no real part
	parameter int         BUSY    = 10
) (
	// Host side pins, lines_in[0] is the serial input line
	input  wire logic       ref_clk_in,
	input  wire logic       select_low_in,
	input  wire logic       shift_clock_in,
	input  wire logic [3:0] lines_in,
	// Reply line
	output logic            serial_out_line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [7:0] op_reg  = 8'h00;
	logic [7:0] sh_reg  = 8'h00;
	logic [7:0] ptr_reg = 8'h00;
	logic [7:0] b;
	logic       wel_reg = 1'b0;
	logic       sel_reg = 1'b1;
	logic       sck_reg = 1'b0;
	int         cnt     = 0;
	int         bc      = 0;
	int         n;
	wire        wip  = bc != 0;
	wire        quad = op_reg == 8'h12 && cnt >= 8;
	wire        prog = op_reg == 8'h02 || op_reg == 8'h12;
	wire        ers  = op_reg == 8'hC7 || op_reg == 8'hC4 || op_reg == 8'hD8;

	initial serial_out_line_out = 1'b0;
	initial foreach (mem[i]) mem[i] = 8'h00;

	// Pins are sampled on the bench clock so edges of the shift clock are seen in order
	always @(posedge ref_clk_in) begin
		sel_reg <= select_low_in;
		sck_reg <= shift_clock_in;
		if (wip) bc <= bc - 1;
		if (select_low_in) begin
			// Deselected: the line keeps changing so a stale sample cannot pass
			serial_out_line_out <= ~serial_out_line_out;
			if (!sel_reg) begin
				cnt <= 0;
				if (op_reg == 8'h06 && cnt == 8) wel_reg <= 1'b1;
				else if (wel_reg && !wip && (prog || ers)) begin
					wel_reg <= 1'b0;
					bc      <= BUSY;
					if (ers) foreach (mem[i]) mem[i] <= 8'hFF;
				end
			end
		end else if (shift_clock_in && !sck_reg) begin
			b = quad ? {sh_reg[3:0], lines_in} : {sh_reg[6:0], lines_in[0]};
			n = cnt + (quad ? 4 : 1);
			sh_reg <= b;
			cnt    <= n;
			if (n == 8) op_reg <= b;
			else if (n == 40) ptr_reg <= b;
			else if (n > 40 && n % 8 == 0 && prog && wel_reg && !wip) begin
				mem[ptr_reg] <= mem[ptr_reg] & b;
				ptr_reg      <= ptr_reg + 8'h01;
			end
		end else if (!shift_clock_in && sck_reg) begin
			if (op_reg == 8'h9F && cnt >= 8 && cnt < 16 && !wip)
				serial_out_line_out <= ID_CODE[3'(cnt - 8)];
			else
				serial_out_line_out <= ~serial_out_line_out;
		end
	end
endmodule : sfp_flash_model

// file: verification/sfp_host_checker.sv
// Concurrent checks on the host's flash pins and handshakes
module sfp_host_checker (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// Observed outputs
	input wire logic select_low_out,
	input wire logic shift_clock_out,
	input wire logic serial_in_line_out,
	input wire logic serial_in_line_oe_out,
	input wire logic serial_out_line_oe_out,
	input wire logic quad_line_2_oe_out,
	input wire logic quad_line_3_oe_out,
	input wire logic cmd_ready_out,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic id_valid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_high_phase;
		shift_clock_out [*4] ##1 !shift_clock_out;
	endsequence

	a_sclk_idle_low: assert property (select_low_out |-> !shift_clock_out)
		else $error("shift clock moved outside a frame");
	a_sclk_high_four: assert property ($rose(shift_clock_out) |-> s_high_phase)
		else $error("shift clock high phase not four cycles");
	a_data_held_high: assert property (
		shift_clock_out && $past(shift_clock_out) |-> $stable(serial_in_line_out))
		else $error("data changed while shift clock high");
	a_drive_in_frame: assert property (!select_low_out |-> serial_in_line_oe_out)
		else $error("serial input line not driven in frame");
	a_quad_in_frame: assert property (
		quad_line_2_oe_out |-> !select_low_out && quad_line_3_oe_out && serial_out_line_oe_out)
		else $error("quad lines driven outside a frame");
	a_frame_busy: assert property (!select_low_out |-> busy_out && !cmd_ready_out)
		else $error("ready while a frame is open");
	a_done_single: assert property (done_out |-> select_low_out ##1 !done_out)
		else $error("done not a single pulse after the frame");
	a_id_with_done: assert property (id_valid_out |-> ##2 done_out)
		else $error("id valid without done");
	a_lines_released: assert property (
		select_low_out |-> !serial_in_line_oe_out && !serial_out_line_oe_out)
		else $error("data lines driven outside a frame");
endmodule : sfp_host_checker

bind sfp_host sfp_host_checker u_chk (.ref_clk_in, .rstn_in, .select_low_out,
	.shift_clock_out, .serial_in_line_out, .serial_in_line_oe_out, .serial_out_line_oe_out,
	.quad_line_2_oe_out, .quad_line_3_oe_out, .cmd_ready_out, .busy_out, .done_out,
	.id_valid_out);

// file: verification/tb.sv
// Self-checking bench for the serial flash program/erase host
module tb import sfp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [2:0] o; logic [31:0] a; logic [7:0] l;} sfp_row_t;
	localparam logic [7:0] ID = 8'h5A; // Arbitrary value, names no real part
	logic        ref_clk = 1'b0;
	logic        rstn    = 1'b0;
	logic        cv      = 1'b0;
	logic        wv      = 1'b0;
	logic        stall   = 1'b0;
	logic [2:0]  op      = 3'h0;
	logic [31:0] ad      = 32'h0;
	logic [7:0]  ln      = 8'h00;
	logic [7:0]  wd      = 8'h00;
	logic [7:0]  nxt     = 8'h00;
	logic [7:0]  p;
	logic [7:0]  idd;
	logic        cr, wr, iv, dn, bs, sel, sck, mo;
	wire  [3:0]  q, qe;
	int          errors  = 0;
	int          checked = 0;
	int          falls   = 0;
	int          t, f;
	// Undriven lines carry a moving pattern, never a held value
	wire  [3:0]  lines = {qe[3] ? q[3] : ref_clk, qe[2] ? q[2] : ref_clk,
	                      qe[1] ? q[1] : mo, qe[0] ? q[0] : ref_clk};
	sfp_row_t    rows [7] = '{'{3'h0, 32'h0, 8'h00}, '{3'h3, 32'h0, 8'h00},
		'{3'h1, 32'hF8, 8'h0F}, '{3'h5, 32'h12345, 8'h00}, '{3'h1, 32'h0, 8'hFF},
		'{3'h4, 32'h2000000, 8'h00}, '{3'h2, 32'h10, 8'h03}};

	always #25 ref_clk = ~ref_clk;
	always @(negedge sel) falls++;
	always @(posedge ref_clk) begin
		if (wv && wr) begin
			wd <= wd + 8'h01;
			wv <= !stall;
		end else if (rstn && !(stall && t % 128 != 0)) wv <= 1'b1; // Slow feed parks the clock
	end

	sfp_host #(.PAGE_PROG_CYCLES(40'd20), .SECTOR_ER_CYCLES(40'd30),
		.BULK_ER_CYCLES(40'd40), .DIE_ER_CYCLES(40'd40)) dut (.ref_clk_in(ref_clk),
		.rstn_in(rstn), .ce_in(1'b1), .cmd_valid_in(cv), .cmd_ready_out(cr),
		.cmd_op_in(op), .cmd_addr_in(ad), .cmd_len_m1_in(ln), .wr_valid_in(wv),
		.wr_ready_out(wr), .wr_data_in(wd), .id_data_out(idd), .id_valid_out(iv),
		.done_out(dn), .busy_out(bs), .select_low_out(sel), .shift_clock_out(sck),
		.serial_in_line_out(q[0]), .serial_in_line_oe_out(qe[0]),
		.serial_out_line_in(lines[1]), .serial_out_line_out(q[1]),
		.serial_out_line_oe_out(qe[1]), .quad_line_2_out(q[2]), .quad_line_2_oe_out(qe[2]),
		.quad_line_3_out(q[3]), .quad_line_3_oe_out(qe[3]));
	sfp_flash_model #(.ID_CODE(ID)) m (.ref_clk_in(ref_clk), .select_low_in(sel),
		.shift_clock_in(sck), .lines_in(lines), .serial_out_line_out(mo));

	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task run(input sfp_row_t r);
		@(posedge ref_clk);
		op <= r.o;
		ad <= r.a;
		ln <= r.l;
		cv <= 1'b1;
		@(posedge ref_clk);
		cv <= 1'b0;
		t = 0;
		do begin
			@(negedge ref_clk);
			t++;
		end while (dn !== 1'b1 && t < 25000);
		if (t == 25000) errors++;
	endtask : run

	task final_report;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	initial begin
		#3_000_000;
		errors++;
		final_report();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			run(rows[i]);
			if (rows[i].o == 3'h0) cmp(idd, ID);
			else if (rows[i].o <= 3'h2) begin
				for (int j = 0; j <= rows[i].l; j++) begin
					p = rows[i].a[7:0] + j[7:0];
					cmp(m.mem[p], nxt + j[7:0]);
				end
				p = rows[i].a[7:0] + rows[i].l + 8'h01;
				if (rows[i].l != 8'hFF) cmp(m.mem[p], 8'hFF);
				nxt = nxt + rows[i].l + 8'h01;
			end else cmp(m.mem[8'hF8], 8'hFF);
			cmp({7'h0, m.wel_reg}, 8'h00);
		end
		// Stalled stream: shift clock parks until the next byte arrives
		stall = 1'b1;
		f = falls;
		run('{3'h1, 32'h80, 8'h05});
		cmp(8'(falls - f), 8'h02);
		for (int j = 0; j < 6; j++) cmp(m.mem[8'h80 + j[7:0]], nxt + j[7:0]);
		stall = 1'b0;
		repeat (4) @(negedge ref_clk);
		cmp({7'h0, wr}, 8'h00);
		// Illegal code is acknowledged without opening a frame
		f = falls;
		run('{3'h7, 32'h0, 8'h00});
		cmp(8'(falls), 8'(f));
		// Reset in mid-frame releases the pins at once
		@(posedge ref_clk);
		op <= 3'h3;
		cv <= 1'b1;
		@(posedge ref_clk);
		cv <= 1'b0;
		repeat (100) @(posedge ref_clk);
		rstn <= 1'b0;
		@(negedge ref_clk);
		cmp({6'h0, sel, sck}, 8'h02);
		cmp({6'h0, cr, bs}, 8'h02);
		@(posedge ref_clk);
		rstn <= 1'b1;
		run('{3'h0, 32'h0, 8'h00});
		cmp(idd, ID);
		final_report();
	end
endmodule : tb
